// file: verilog/ica_ctrl_addr.sv
`timescale 1ns/1ps
`default_nettype none
`include "ica_consts.svh"

module ica_ctrl_addr (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_dma_tx_eot,
  input wire logic i_dma_rx_eot,
  input wire logic i_tx_fifo_space,
  input wire logic i_rx_fifo_data,
  output logic o_dma_tx_run,
  output logic o_dma_rx_run,
  output logic o_dma_tx_req,
  output logic o_dma_rx_req,
  output logic [6:0] o_own_address_low,
  output logic [2:0] o_own_address_high,
  output logic [9:0] o_own_address_10b,
  input wire logic i_kernel_clk,
  input wire logic i_sda_in,
  input wire logic i_scl_in,
  output logic o_sda_filt,
  output logic o_scl_filt,
  input wire logic i_stretch_release,
  output logic o_setup_done,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_stop_active
);

  logic wr_ctrl;
  logic wr_addr;
  logic [1:0] glitch_filter_select;
  logic forced_stop_request;
  logic [15:0] target_data_setup_count;
  logic stop_done_meta;
  logic stop_done_s;
  logic cfg_dirty;
  logic cfg_req_tg;
  logic [17:0] cfg_shadow;
  logic cfg_ack_meta;
  logic cfg_ack_s;
  logic wrote_addr;
  logic cfg_ack_k;
  logic stop_done_k;

  assign wr_ctrl = i_wr && (i_addr == `ICA_OFS_CTRL);
  assign wr_addr = i_wr && (i_addr == `ICA_OFS_ADDR);

  // A write in the same cycle as end-of-transfer wins over the clear.
  // transmit enable clear
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dma_tx_run <= 1'b0;
    end else if (wr_ctrl) begin
      o_dma_tx_run <= i_wdata[`ICA_BIT_DMA_TX];
    end else if (i_dma_tx_eot) begin
      o_dma_tx_run <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dma_rx_run <= 1'b0;
    end else if (wr_ctrl) begin
      o_dma_rx_run <= i_wdata[`ICA_BIT_DMA_RX];
    end else if (i_dma_rx_eot) begin
      o_dma_rx_run <= 1'b0;
    end
  end

  assign o_dma_rx_req = o_dma_rx_run && i_rx_fifo_data;
  assign o_dma_tx_req = o_dma_tx_run && i_tx_fifo_space;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      glitch_filter_select <= `ICA_FLT_RST;
    end else if (wr_ctrl) begin
      glitch_filter_select <= i_wdata[`ICA_FLT_HI:`ICA_FLT_LO];
    end
  end

  // The request stays set until the link side reports the STOP as sent.
  // forced stop request
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      forced_stop_request <= 1'b0;
    end else if (wr_ctrl) begin
      forced_stop_request <= i_wdata[`ICA_BIT_FSTOP];
    end else if (stop_done_s) begin
      forced_stop_request <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_own_address_low <= `ICA_OAL_RST;
      o_own_address_high <= `ICA_OAH_RST;
      target_data_setup_count <= `ICA_TARGET_DATA_SETUP_COUNT_RST;
    end else if (wr_addr) begin
      o_own_address_low <= i_wdata[`ICA_OAL_HI:`ICA_OAL_LO];
      o_own_address_high <= i_wdata[`ICA_OAH_HI:`ICA_OAH_LO];
      target_data_setup_count <= i_wdata[`ICA_TARGET_DATA_SETUP_COUNT_HI:`ICA_TARGET_DATA_SETUP_COUNT_LO];
    end
  end

  assign o_own_address_10b = {o_own_address_high, o_own_address_low};

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= 32'h0000_0000;
      case (i_addr)
        `ICA_OFS_CTRL: begin
          o_rdata[`ICA_BIT_DMA_TX] <= o_dma_tx_run;
          o_rdata[`ICA_BIT_DMA_RX] <= o_dma_rx_run;
          o_rdata[`ICA_FLT_HI:`ICA_FLT_LO] <= glitch_filter_select;
          o_rdata[`ICA_BIT_FSTOP] <= forced_stop_request;
        end
        `ICA_OFS_ADDR: begin
          o_rdata[`ICA_OAL_HI:`ICA_OAL_LO] <= o_own_address_low;
          o_rdata[`ICA_OAH_HI:`ICA_OAH_LO] <= o_own_address_high;
          o_rdata[`ICA_TARGET_DATA_SETUP_COUNT_HI:`ICA_TARGET_DATA_SETUP_COUNT_LO] <= target_data_setup_count;
        end
        default: begin
          o_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // Configuration words reach the link side by a toggle handshake.
  // The shadow only reloads once the previous word has been acknowledged.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_dirty <= 1'b0;
      cfg_req_tg <= 1'b0;
      cfg_shadow <= {`ICA_TARGET_DATA_SETUP_COUNT_RST, `ICA_FLT_RST};
    end else if (cfg_dirty && (cfg_req_tg == cfg_ack_s) && !(wr_ctrl || wr_addr)) begin
      cfg_dirty <= 1'b0;
      cfg_req_tg <= ~cfg_req_tg;
      cfg_shadow <= {target_data_setup_count, glitch_filter_select};
    end else if (wr_ctrl || wr_addr) begin
      cfg_dirty <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_ack_meta <= 1'b0;
      cfg_ack_s <= 1'b0;
      stop_done_meta <= 1'b0;
      stop_done_s <= 1'b0;
    end else begin
      cfg_ack_meta <= cfg_ack_k;
      cfg_ack_s <= cfg_ack_meta;
      stop_done_meta <= stop_done_k;
      stop_done_s <= stop_done_meta;
    end
  end

  // ---------------- Link side, kernel clock domain ----------------
  logic krst_meta;
  logic krst_n;
  logic cfg_req_meta;
  logic cfg_req_s;
  logic [1:0] k_flt;
  logic [15:0] k_target_data_setup_count;
  logic fs_meta;
  logic fs_s;
  logic [1:0] pin_meta;
  logic [1:0] pin_s;
  logic [1:0] filt;
  logic [2:0] kwidth;
  logic [15:0] setup_cnt;
  logic [15:0] ph_cnt;
  ica_pkg::ica_stop_state_t stop_state;
  ica_pkg::ica_stop_state_t next_stop_state;

  always_ff @(posedge i_kernel_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      krst_meta <= 1'b0;
      krst_n <= 1'b0;
    end else begin
      krst_meta <= 1'b1;
      krst_n <= krst_meta;
    end
  end

  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      cfg_req_meta <= 1'b0;
      cfg_req_s <= 1'b0;
      fs_meta <= 1'b0;
      fs_s <= 1'b0;
      pin_meta <= 2'h3;
      pin_s <= 2'h3;
    end else begin
      cfg_req_meta <= cfg_req_tg;
      cfg_req_s <= cfg_req_meta;
      fs_meta <= forced_stop_request;
      fs_s <= fs_meta;
      pin_meta <= {i_scl_in, i_sda_in};
      pin_s <= pin_meta;
    end
  end

  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      cfg_ack_k <= 1'b0;
      k_flt <= `ICA_FLT_RST;
      k_target_data_setup_count <= `ICA_TARGET_DATA_SETUP_COUNT_RST;
    end else if (cfg_req_s != cfg_ack_k) begin
      cfg_ack_k <= cfg_req_s;
      k_flt <= cfg_shadow[1:0];
      k_target_data_setup_count <= cfg_shadow[17:2];
    end
  end

  always_comb begin
    case (k_flt)
      2'h0: kwidth = `ICA_FLT_W0;
      2'h1: kwidth = `ICA_FLT_W1;
      2'h2: kwidth = `ICA_FLT_W2;
      default: kwidth = `ICA_FLT_W3;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filter
      logic [2:0] run;
      always_ff @(posedge i_kernel_clk or negedge krst_n) begin
        if (!krst_n) begin
          run <= 3'h0;
          filt[g] <= 1'b1;
        end else if (pin_s[g] == filt[g]) begin
          run <= 3'h0;
        end else if (run >= kwidth) begin
          run <= 3'h0;
          filt[g] <= pin_s[g];
        end else begin
          run <= 3'(run + 3'h1);
        end
      end
    end
  endgenerate

  assign o_sda_filt = filt[0];
  assign o_scl_filt = filt[1];

  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      setup_cnt <= 16'h0000;
      o_setup_done <= 1'b0;
    end else if (i_stretch_release) begin
      o_setup_done <= (k_target_data_setup_count <= `ICA_SETUP_MIN);
      setup_cnt <= (k_target_data_setup_count <= `ICA_SETUP_MIN) ? 16'h0000 : 16'(k_target_data_setup_count - `ICA_SETUP_MIN);
    end else begin
      o_setup_done <= (setup_cnt == 16'h0001);
      if (setup_cnt != 16'h0000) begin
        setup_cnt <= 16'(setup_cnt - 16'h0001);
      end
    end
  end

  always_comb begin
    next_stop_state = stop_state;
    case (stop_state)
      ica_pkg::ICA_ST_IDLE: begin
        if (fs_s && !stop_done_k) begin
          next_stop_state = ica_pkg::ICA_ST_DRIVE_LO;
        end
      end
      ica_pkg::ICA_ST_DRIVE_LO: begin
        if (ph_cnt == 16'h0000) begin
          next_stop_state = ica_pkg::ICA_ST_SCL_HI;
        end
      end
      ica_pkg::ICA_ST_SCL_HI: begin
        if (ph_cnt == 16'h0000) begin
          next_stop_state = ica_pkg::ICA_ST_SDA_HI;
        end
      end
      ica_pkg::ICA_ST_SDA_HI: begin
        if (ph_cnt == 16'h0000) begin
          next_stop_state = ica_pkg::ICA_ST_IDLE;
        end
      end
      default: begin
        next_stop_state = ica_pkg::ICA_ST_IDLE;
      end
    endcase
  end

  // Each phase lasts one kernel cycle more than the programmed setup count.
  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      stop_state <= ica_pkg::ICA_ST_IDLE;
      ph_cnt <= 16'h0000;
    end else begin
      stop_state <= next_stop_state;
      if (next_stop_state != stop_state) begin
        ph_cnt <= k_target_data_setup_count;
      end else if (ph_cnt != 16'h0000) begin
        ph_cnt <= 16'(ph_cnt - 16'h0001);
      end
    end
  end

  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      stop_done_k <= 1'b0;
    end else if (!fs_s) begin
      stop_done_k <= 1'b0;
    end else if (stop_state == ica_pkg::ICA_ST_SDA_HI && ph_cnt == 16'h0000) begin
      stop_done_k <= 1'b1;
    end
  end

  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = (stop_state == ica_pkg::ICA_ST_DRIVE_LO);
  assign o_sda_oe = (stop_state == ica_pkg::ICA_ST_DRIVE_LO) ||
                    (stop_state == ica_pkg::ICA_ST_SCL_HI);
  assign o_stop_active = (stop_state != ica_pkg::ICA_ST_IDLE);

  // Helper state read only by the checks below.
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wrote_addr <= 1'b0;
    end else if (wr_addr) begin
      wrote_addr <= 1'b1;
    end
  end

  logic [2:0] sda_diff_run;
  always_ff @(posedge i_kernel_clk or negedge krst_n) begin
    if (!krst_n) begin
      sda_diff_run <= 3'h0;
    end else if (pin_s[0] == o_sda_filt) begin
      sda_diff_run <= 3'h0;
    end else if (sda_diff_run != 3'h7) begin
      sda_diff_run <= 3'(sda_diff_run + 3'h1);
    end
  end

  a_tx_eot_clear: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_dma_tx_eot && !wr_ctrl) |=> !o_dma_tx_run
  ) else $error("transmit DMA enable not cleared by end of transfer");

  a_rx_run_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    ((wr_ctrl && i_wdata[`ICA_BIT_DMA_RX]) ||
     (o_dma_rx_run && !i_dma_rx_eot && !wr_ctrl)) |=> o_dma_rx_run
  ) else $error("receive DMA enable lost without cause");

  a_rx_req_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (wr_ctrl && !i_wdata[`ICA_BIT_DMA_RX]) |=> !o_dma_rx_req
  ) else $error("receive DMA request while disabled");

  a_flt_sel_store: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_ctrl |=> glitch_filter_select == $past(i_wdata[`ICA_FLT_HI:`ICA_FLT_LO])
  ) else $error("filter select not stored");

  a_flt_spike_block: assert property (
    @(posedge i_kernel_clk) disable iff (!krst_n)
    $changed(o_sda_filt) |-> $past(sda_diff_run) >= $past(kwidth)
  ) else $error("data line spike passed the filter");

  a_flt_width_four: assert property (
    @(posedge i_kernel_clk) disable iff (!krst_n)
    ($past(k_flt) == 2'h3 && $changed(o_sda_filt)) |-> $past(sda_diff_run) >= `ICA_FLT_W3
  ) else $error("filter code three does not hold off four cycles");

  a_stop_start: assert property (
    @(posedge i_kernel_clk) disable iff (!krst_n)
    (stop_state == ica_pkg::ICA_ST_IDLE && fs_s && !stop_done_k) |=> o_scl_oe && o_sda_oe
  ) else $error("forced stop did not drive the bus");

  a_addr_reset_val: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !wrote_addr |-> (o_own_address_low == `ICA_OAL_RST) &&
                    (target_data_setup_count == `ICA_TARGET_DATA_SETUP_COUNT_RST)
  ) else $error("own address or setup count lost reset value");

  a_addr_high_store: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    wr_addr |=> o_own_address_10b[9:7] == $past(i_wdata[`ICA_OAH_HI:`ICA_OAH_LO])
  ) else $error("own address high field not stored");

  a_setup_minus_one: assert property (
    @(posedge i_kernel_clk) disable iff (!krst_n)
    (i_stretch_release && k_target_data_setup_count == 16'h0005) ##1 (!i_stretch_release)[*3] |->
      !o_setup_done ##1 o_setup_done
  ) else $error("setup delay is not count minus one");

endmodule
`default_nettype wire

// file: inc/ica_consts.svh
`ifndef ICA_CONSTS_SVH
`define ICA_CONSTS_SVH
`define ICA_OFS_CTRL 8'h00
`define ICA_OFS_ADDR 8'h04
`define ICA_BIT_DMA_TX 9
`define ICA_BIT_DMA_RX 10
`define ICA_FLT_HI 14
`define ICA_FLT_LO 13
`define ICA_BIT_FSTOP 15
`define ICA_OAL_HI 6
`define ICA_OAL_LO 0
`define ICA_OAH_HI 9
`define ICA_OAH_LO 7
`define ICA_TARGET_DATA_SETUP_COUNT_HI 31
`define ICA_TARGET_DATA_SETUP_COUNT_LO 16
`define ICA_OAL_RST 7'h55
`define ICA_OAH_RST 3'h0
`define ICA_TARGET_DATA_SETUP_COUNT_RST 16'h000F
`define ICA_FLT_RST 2'h0
`define ICA_FLT_W0 3'h0
`define ICA_FLT_W1 3'h1
`define ICA_FLT_W2 3'h2
`define ICA_FLT_W3 3'h4
`define ICA_SETUP_MIN 16'h0002
`endif

// file: inc/ica_pkg.sv
package ica_pkg;
  typedef enum logic [3:0] {
    ICA_ST_IDLE     = 4'b0001,
    ICA_ST_DRIVE_LO = 4'b0010,
    ICA_ST_SCL_HI   = 4'b0100,
    ICA_ST_SDA_HI   = 4'b1000
  } ica_stop_state_t;
endpackage

// file: tb/ica_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ica_far_side (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_tx_req,
  input wire logic i_rx_req,
  input wire logic i_slow,
  input wire logic [3:0] i_burst,
  output logic o_tx_eot,
  output logic o_rx_eot,
  input wire logic i_sda_oe,
  input wire logic i_scl_oe,
  input wire logic i_line_drv,
  output logic o_sda,
  output logic o_scl
);
  logic [3:0] served;
  logic [1:0] pace;
  logic take;
  // Pull-ups hold both lines high unless a party pulls them low.
  assign o_sda = i_line_drv & ~i_sda_oe;
  assign o_scl = i_line_drv & ~i_scl_oe;
  // A slow controller serves one request in four cycles.
  assign take = (i_tx_req | i_rx_req) & (~i_slow | (pace == 2'h0)) & ~o_tx_eot & ~o_rx_eot;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      served <= 4'h0;
      pace <= 2'h0;
      o_tx_eot <= 1'b0;
      o_rx_eot <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      o_tx_eot <= 1'b0;
      o_rx_eot <= 1'b0;
      if (take && served == i_burst) begin
        served <= 4'h0;
        o_tx_eot <= i_tx_req;
        o_rx_eot <= i_rx_req;
      end else if (take) begin
        served <= served + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/ica_ctrl_addr_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ica_ctrl_addr_tb;
  logic clk = 1'b0;
  logic kclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic tx_space = 1'b0;
  logic rx_data = 1'b0;
  logic drv = 1'b1;
  logic stretch = 1'b0;
  logic slow = 1'b0;
  logic [3:0] burst = 4'h3;
  logic [31:0] rdata, d;
  logic tx_eot, rx_eot, sda, scl, tx_run, rx_run, tx_req, rx_req;
  logic sda_f, scl_f, done, sda_oe, scl_oe, stop_on, stp, psda, on, sda_o, scl_o;
  logic [6:0] own_lo;
  logic [2:0] own_hi;
  logic [9:0] own10;
  logic [1:0] seen;
  int errors = 0;
  int checks_done = 0;
  int k, w, n1, n2;
  int nl[4] = '{12, 2, 5, 3};

  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3;
    forever #7.5 kclk = ~kclk;
  end

  ica_ctrl_addr i_dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_dma_tx_eot(tx_eot), .i_dma_rx_eot(rx_eot),
    .i_tx_fifo_space(tx_space), .i_rx_fifo_data(rx_data), .o_dma_tx_run(tx_run),
    .o_dma_rx_run(rx_run), .o_dma_tx_req(tx_req), .o_dma_rx_req(rx_req),
    .o_own_address_low(own_lo), .o_own_address_high(own_hi), .o_own_address_10b(own10),
    .i_kernel_clk(kclk), .i_sda_in(sda), .i_scl_in(scl), .o_sda_filt(sda_f),
    .o_scl_filt(scl_f), .i_stretch_release(stretch), .o_setup_done(done), .o_sda_out(sda_o),
    .o_sda_oe(sda_oe), .o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_stop_active(stop_on)
  );

  ica_far_side i_far (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_tx_req(tx_req), .i_rx_req(rx_req),
    .i_slow(slow), .i_burst(burst), .o_tx_eot(tx_eot), .o_rx_eot(rx_eot),
    .i_sda_oe(sda_oe), .i_scl_oe(scl_oe), .i_line_drv(drv), .o_sda(sda), .o_scl(scl)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic waited(input int n, input int lim);
    if (n >= lim) begin
      check(n, lim - 1);
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  // Pulls both lines low for n kernel cycles and records the filtered levels.
  task automatic glitch(input int n, output logic [1:0] s);
    @(posedge kclk);
    s = 2'b00;
    drv <= 1'b0;
    for (int j = 1; j < n + 14; j++) begin
      @(posedge kclk);
      if (j == n) drv <= 1'b1;
      #1;
      s |= {~(sda_f & scl_f), ~(sda_f | scl_f)};
    end
  endtask

  always @(posedge clk) begin
    tx_space <= 1'($urandom);
    rx_data <= 1'($urandom);
  end

  always @(negedge clk) begin
    if (rst_n) begin
      check({30'h0, tx_req, rx_req}, {30'h0, tx_run & tx_space, rx_run & rx_data});
    end
  end

  initial begin
    void'($urandom(32'h3cc3));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(8'h04, 32'h000f_0055);
    check({25'h0, own_lo}, 32'h0000_0055);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h0c, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      d = $urandom & 32'h0fff_ffff;
      wr(8'h04, d);
      rdchk(8'h04, d & 32'h0fff_03ff);
      check({22'h0, own10}, {22'h0, d[9:0]});
      check({29'h0, own_hi}, {29'h0, d[9:7]});
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c) << 13);
      rdchk(8'h00, 32'(c) << 13);
      repeat (30) @(posedge clk);
      w = (c == 3) ? 4 : c;
      if (w > 0) begin
        glitch(w, seen);
        check({30'h0, seen}, 32'h0000_0000);
      end
      glitch(w + 1, seen);
      check({31'h0, seen[0]}, 32'h0000_0001);
    end
    for (int j = 0; j < 2; j++) begin
      slow <= j[0];
      burst <= 4'($urandom_range(2, 9));
      wr(8'h00, 32'h0000_0200 << j);
      #1;
      check({30'h0, rx_run, tx_run}, 32'h0000_0001 << j);
      k = 0;
      while ((tx_run | rx_run) && k < 300) begin
        @(posedge clk);
        k++;
      end
      waited(k, 300);
      rdchk(8'h00, 32'h0000_0000);
    end
    wr(8'h00, 32'h0000_0400);
    @(posedge clk);
    wr(8'h00, 32'h0000_0000);
    #1;
    check({31'h0, rx_run}, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, {16'(nl[i]), 16'h0055});
      repeat (30) @(posedge clk);
      @(posedge kclk);
      stretch <= 1'b1;
      k = 0;
      do begin
        @(posedge kclk);
        stretch <= 1'b0;
        #1;
        k++;
      end while (!done && k < 40);
      waited(k, 40);
      check(k, (nl[i] <= 2) ? 1 : nl[i] - 1);
    end
    @(posedge clk);
    wr(8'h00, 32'h0000_8000);
    rdchk(8'h00, 32'h0000_8000);
    k = 0;
    n1 = 0;
    n2 = 0;
    stp = 1'b0;
    on = 1'b0;
    psda = sda;
    while (k < 200 && !(on && !stop_on)) begin
      @(negedge kclk);
      on |= stop_on;
      if (stop_on && scl_oe && sda_oe) n1++;
      else if (stop_on && sda_oe) n2++;
      if (scl && sda && !psda) stp = 1'b1;
      psda = sda;
      k++;
    end
    waited(k, 200);
    check(n1, 4);
    check(n2, 4);
    check({30'h0, sda_o, scl_o}, 32'h0000_0000);
    check({31'h0, stp}, 32'h0000_0001);
    k = 0;
    d = 32'h0000_8000;
    while (d[15] && k < 20) begin
      rd(8'h00, d);
      k++;
    end
    waited(k, 20);
    check(d, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
